// ### hw/bp_ctrl_pkg.sv
// constants, field layout and carrier types of the breakpoint control unit
// How it works
// - mode bit 31 enables breakpoints, reset disabled
// - bit 24 ANDs composite breakpoint groups
// - bit 20 arms data memory breakpoints
// - bit 19 arms program memory breakpoint
// - bit 21 arms instruction address breakpoints
// - bits 27 and 26 arm slave ports
// - bit 25 qualifies breakpoints with user mode
// - bit 17 inverts both slave port matches
// - bits 13 to 16 invert instruction matches
// - bits 11, 12 invert data memory matches
// - bit 10 inverts program memory match
// - bits 7:6 slave port trigger select
// - bits 3:2, 5:4 data memory trigger select
// - bits 1:0 program memory trigger select
// - every control field reads and writes
// - each hit sets its own status flag
`default_nettype none
package bp_ctrl_pkg;
  localparam int ADDR_W = 32;
  localparam int NUM_BP = 9;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_RANGE = 12'h040;
  localparam logic [11:0] OFS_RANGE_END = 12'h088;
  // control fields
  localparam int CTL_MODE_ON = 31;
  localparam int CTL_SP1_ARM = 27;
  localparam int CTL_SP2_ARM = 26;
  localparam int CTL_USER_QUAL = 25;
  localparam int CTL_COMBINE = 24;
  localparam int CTL_IA_ARM = 21;
  localparam int CTL_DM_ARM = 20;
  localparam int CTL_PM_ARM = 19;
  localparam int CTL_SP_INV = 17;
  localparam int CTL_IA_INV = 13;
  localparam int CTL_DM_INV = 11;
  localparam int CTL_PM_INV = 10;
  localparam int CTL_SP_SEL = 6;
  localparam int CTL_DM2_SEL = 4;
  localparam int CTL_DM1_SEL = 2;
  localparam int CTL_PM_SEL = 0;
  localparam logic [31:0] CTRL_RW_MASK = 32'h8F3B_FCFF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status flag positions, entry order pm, dm1, dm2, ia1..ia4, sp1, sp2
  localparam int STAT_POS [NUM_BP] = '{0, 1, 2, 3, 4, 5, 6, 7, 16};
  localparam logic [31:0] RANGE_RESET = 32'h0000_0000;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // trigger select encodings
  typedef enum logic [1:0] {TRIG_OFF, TRIG_READ, TRIG_WRITE, TRIG_ANY} trig_sel_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic valid;
    logic write;
  } mem_access_t;
endpackage
`default_nettype wire

// ### hw/bp_ctrl_unit.sv
// breakpoint control unit with axi4-lite register slave
`default_nettype none
module bp_ctrl_unit #(
  parameter int NUM_BP = bp_ctrl_pkg::NUM_BP
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core address buses
  input wire bp_ctrl_pkg::mem_access_t instr_access,
  input wire bp_ctrl_pkg::mem_access_t program_memory_data_addr,
  input wire bp_ctrl_pkg::mem_access_t data_memory_data_addr,
  input wire bp_ctrl_pkg::mem_access_t slave_port1_access,
  input wire bp_ctrl_pkg::mem_access_t slave_port2_access,
  input wire logic core_user_mode,
  // breakpoint outputs
  output logic breakpoint_hit,
  output logic [31:0] breakpoint_hit_flags
);
  logic [31:0] breakpoint_control;
  logic [31:0] range_start_reg [NUM_BP];
  logic [31:0] range_end_reg [NUM_BP];
  logic [NUM_BP-1:0] flag_reg;
  logic [NUM_BP-1:0] raw_fire;
  logic [NUM_BP-1:0] fire;
  logic [NUM_BP-1:0] arm;
  logic [NUM_BP-1:0] invert;
  bp_ctrl_pkg::trig_sel_t trig [NUM_BP];
  bp_ctrl_pkg::mem_access_t acc [NUM_BP];
  logic hit_reg;
  logic hit_next;
  logic qualify;
  logic grp_pm;
  logic grp_dm;
  logic grp_ia;
  logic grp_sp;
  logic any_armed;
  logic all_hit;

  // bus side state
  logic [31:0] aw_addr_reg;
  logic aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic [31:0] wr_mask;
  logic [31:0] stat_clear;

  // control field fan-out to the comparators
  always_comb
  begin
    acc[0] = program_memory_data_addr;
    acc[1] = data_memory_data_addr;
    acc[2] = data_memory_data_addr;
    acc[7] = slave_port1_access;
    acc[8] = slave_port2_access;
    arm[0] = breakpoint_control[bp_ctrl_pkg::CTL_PM_ARM];
    arm[1] = breakpoint_control[bp_ctrl_pkg::CTL_DM_ARM];
    arm[2] = breakpoint_control[bp_ctrl_pkg::CTL_DM_ARM];
    arm[7] = breakpoint_control[bp_ctrl_pkg::CTL_SP1_ARM];
    arm[8] = breakpoint_control[bp_ctrl_pkg::CTL_SP2_ARM];
    invert[0] = breakpoint_control[bp_ctrl_pkg::CTL_PM_INV];
    invert[1] = breakpoint_control[bp_ctrl_pkg::CTL_DM_INV];
    invert[2] = breakpoint_control[bp_ctrl_pkg::CTL_DM_INV + 1];
    invert[7] = breakpoint_control[bp_ctrl_pkg::CTL_SP_INV];
    invert[8] = breakpoint_control[bp_ctrl_pkg::CTL_SP_INV];
    trig[0] = bp_ctrl_pkg::trig_sel_t'(breakpoint_control[bp_ctrl_pkg::CTL_PM_SEL +: 2]);
    trig[1] = bp_ctrl_pkg::trig_sel_t'(breakpoint_control[bp_ctrl_pkg::CTL_DM1_SEL +: 2]);
    trig[2] = bp_ctrl_pkg::trig_sel_t'(breakpoint_control[bp_ctrl_pkg::CTL_DM2_SEL +: 2]);
    trig[7] = bp_ctrl_pkg::trig_sel_t'(breakpoint_control[bp_ctrl_pkg::CTL_SP_SEL +: 2]);
    trig[8] = bp_ctrl_pkg::trig_sel_t'(breakpoint_control[bp_ctrl_pkg::CTL_SP_SEL +: 2]);
    for (int k = 0; k < 4; k++)
    begin
      // instruction fetches have no trigger field: any access counts
      acc[3 + k] = instr_access;
      arm[3 + k] = breakpoint_control[bp_ctrl_pkg::CTL_IA_ARM];
      invert[3 + k] = breakpoint_control[bp_ctrl_pkg::CTL_IA_INV + k];
      trig[3 + k] = bp_ctrl_pkg::TRIG_ANY;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BP; gi++)
    begin : g_bp
      bp_range_match #(
        .ADDR_W(bp_ctrl_pkg::ADDR_W)
      ) u_match (
        .access(acc[gi]),
        .start_addr(range_start_reg[gi]),
        .end_addr(range_end_reg[gi]),
        .arm(arm[gi]),
        .invert(invert[gi]),
        .trig(trig[gi]),
        .fire(raw_fire[gi])
      );
    end
  endgenerate

  // global gating by mode and user qualifier
  assign qualify = breakpoint_control[bp_ctrl_pkg::CTL_MODE_ON] &&
    (!breakpoint_control[bp_ctrl_pkg::CTL_USER_QUAL] || core_user_mode);
  assign fire = qualify ? raw_fire : '0;

  // composite groups
  assign grp_pm = fire[0];
  assign grp_dm = |fire[2:1];
  assign grp_ia = |fire[6:3];
  assign grp_sp = |fire[8:7];
  assign any_armed = breakpoint_control[bp_ctrl_pkg::CTL_PM_ARM] || breakpoint_control[bp_ctrl_pkg::CTL_DM_ARM] ||
    breakpoint_control[bp_ctrl_pkg::CTL_IA_ARM] || breakpoint_control[bp_ctrl_pkg::CTL_SP1_ARM] ||
    breakpoint_control[bp_ctrl_pkg::CTL_SP2_ARM];
  // an unarmed group must not veto the and of the armed ones
  assign all_hit = any_armed &&
    (grp_pm || !breakpoint_control[bp_ctrl_pkg::CTL_PM_ARM]) &&
    (grp_dm || !breakpoint_control[bp_ctrl_pkg::CTL_DM_ARM]) &&
    (grp_ia || !breakpoint_control[bp_ctrl_pkg::CTL_IA_ARM]) &&
    (grp_sp || !(breakpoint_control[bp_ctrl_pkg::CTL_SP1_ARM] || breakpoint_control[bp_ctrl_pkg::CTL_SP2_ARM]));
  assign hit_next = breakpoint_control[bp_ctrl_pkg::CTL_COMBINE] ? all_hit : (|fire);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      hit_reg <= 1'b0;
    else
      hit_reg <= hit_next;
  end
  assign breakpoint_hit = hit_reg;

  // axi write side
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  always_comb
  begin
    wr_mask = '0;
    for (int b = 0; b < 4; b++)
      wr_mask[8*b +: 8] = {8{w_strb_reg[b]}};
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
    else if (do_write)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    else if (do_write)
      w_full_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= bp_ctrl_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      if (aw_addr_reg[11:0] == bp_ctrl_pkg::OFS_CTRL || aw_addr_reg[11:0] == bp_ctrl_pkg::OFS_STAT ||
          (aw_addr_reg[11:0] >= bp_ctrl_pkg::OFS_RANGE && aw_addr_reg[11:0] < bp_ctrl_pkg::OFS_RANGE_END))
        bresp_reg <= bp_ctrl_pkg::RESP_OKAY;
      else
        bresp_reg <= bp_ctrl_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // control register, reserved bits 30:28, 23:22, 18 and 9:8 stay zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      breakpoint_control <= bp_ctrl_pkg::CTRL_RESET;
    else if (do_write && aw_addr_reg[11:0] == bp_ctrl_pkg::OFS_CTRL)
      breakpoint_control <= ((breakpoint_control & ~wr_mask) | (w_data_reg & wr_mask)) &
        bp_ctrl_pkg::CTRL_RW_MASK;
  end

  // range registers: start at even word, end at odd word
  generate
    for (gi = 0; gi < NUM_BP; gi++)
    begin : g_range
      localparam logic [11:0] START_OFS = 12'(bp_ctrl_pkg::OFS_RANGE + 8 * gi);
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          range_start_reg[gi] <= bp_ctrl_pkg::RANGE_RESET;
          range_end_reg[gi] <= bp_ctrl_pkg::RANGE_RESET;
        end
        else if (do_write && aw_addr_reg[11:0] == START_OFS)
          range_start_reg[gi] <= (range_start_reg[gi] & ~wr_mask) | (w_data_reg & wr_mask);
        else if (do_write && aw_addr_reg[11:0] == START_OFS + 12'h004)
          range_end_reg[gi] <= (range_end_reg[gi] & ~wr_mask) | (w_data_reg & wr_mask);
      end
    end
  endgenerate

  // hit flags: write one to clear, a new hit in the same cycle wins
  assign stat_clear = (do_write && aw_addr_reg[11:0] == bp_ctrl_pkg::OFS_STAT) ? (w_data_reg & wr_mask) : '0;
  generate
    for (gi = 0; gi < NUM_BP; gi++)
    begin : g_flag
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          flag_reg[gi] <= 1'b0;
        else if (fire[gi])
          flag_reg[gi] <= 1'b1;
        else if (stat_clear[bp_ctrl_pkg::STAT_POS[gi]])
          flag_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  always_comb
  begin
    breakpoint_hit_flags = '0;
    for (int i = 0; i < NUM_BP; i++)
      breakpoint_hit_flags[bp_ctrl_pkg::STAT_POS[i]] = flag_reg[i];
  end

  // axi read side, one cycle from address to data
  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= bp_ctrl_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= bp_ctrl_pkg::RESP_OKAY;
      if (s_axi_araddr[11:0] == bp_ctrl_pkg::OFS_CTRL)
        rdata_reg <= breakpoint_control;
      else if (s_axi_araddr[11:0] == bp_ctrl_pkg::OFS_STAT)
        rdata_reg <= breakpoint_hit_flags;
      else if (s_axi_araddr[11:0] >= bp_ctrl_pkg::OFS_RANGE && s_axi_araddr[11:0] < bp_ctrl_pkg::OFS_RANGE_END)
        rdata_reg <= s_axi_araddr[2] ? range_end_reg[4'(s_axi_araddr[11:3] - 9'(bp_ctrl_pkg::OFS_RANGE >> 3))] :
          range_start_reg[4'(s_axi_araddr[11:3] - 9'(bp_ctrl_pkg::OFS_RANGE >> 3))];
      else
      begin
        rdata_reg <= '0;
        rresp_reg <= bp_ctrl_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // checks
  chk_mode_off_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
    !breakpoint_control[bp_ctrl_pkg::CTL_MODE_ON] |=> !breakpoint_hit)
    else $error("hit while breakpoint mode off");
  chk_combine_and: assert property (@(posedge sys_clk) disable iff (!rstn)
    (breakpoint_control[bp_ctrl_pkg::CTL_COMBINE] && breakpoint_control[bp_ctrl_pkg::CTL_IA_ARM] && !grp_ia)
    |=> !breakpoint_hit)
    else $error("combined hit without instruction group");
  chk_dmem_arm: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!breakpoint_control[bp_ctrl_pkg::CTL_DM_ARM] && !flag_reg[1]) |=> !flag_reg[1])
    else $error("dmem flag set while unarmed");
  chk_pmem_arm: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!breakpoint_control[bp_ctrl_pkg::CTL_PM_ARM] && !flag_reg[0]) |=> !flag_reg[0])
    else $error("pmem flag set while unarmed");
  chk_instr_arm: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!breakpoint_control[bp_ctrl_pkg::CTL_IA_ARM] && flag_reg[6:3] == 4'h0) |=> flag_reg[6:3] == 4'h0)
    else $error("instr flag set while unarmed");
  chk_user_qual: assert property (@(posedge sys_clk) disable iff (!rstn)
    (breakpoint_control[bp_ctrl_pkg::CTL_USER_QUAL] && !core_user_mode) |=> !breakpoint_hit)
    else $error("hit outside user mode");
  chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
    (flag_reg[0] && !stat_clear[bp_ctrl_pkg::STAT_POS[0]]) |=> flag_reg[0])
    else $error("hit flag dropped without clear");
  chk_hit_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
    (fire[8] && !breakpoint_control[bp_ctrl_pkg::CTL_COMBINE]) |=> breakpoint_hit && flag_reg[8])
    else $error("slave port hit not reported");
  chk_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    (do_write && aw_addr_reg[11:0] == bp_ctrl_pkg::OFS_CTRL && w_strb_reg == 4'hF)
    |=> breakpoint_control == ($past(w_data_reg) & bp_ctrl_pkg::CTRL_RW_MASK))
    else $error("control write not stored");
endmodule
`default_nettype wire

// ### hw/bp_range_match.sv
// one address breakpoint comparator
`default_nettype none
module bp_range_match #(
  parameter int ADDR_W = 32
) (
  // monitored access
  input wire bp_ctrl_pkg::mem_access_t access,
  // configuration
  input wire logic [ADDR_W-1:0] start_addr,
  input wire logic [ADDR_W-1:0] end_addr,
  input wire logic arm,
  input wire logic invert,
  input wire bp_ctrl_pkg::trig_sel_t trig,
  // result
  output logic fire
);
  logic in_range;
  logic type_ok;
  assign in_range = (access.addr >= start_addr) && (access.addr <= end_addr);
  always_comb
  begin
    case (trig)
      bp_ctrl_pkg::TRIG_READ: type_ok = !access.write;
      bp_ctrl_pkg::TRIG_WRITE: type_ok = access.write;
      bp_ctrl_pkg::TRIG_ANY: type_ok = 1'b1;
      default: type_ok = 1'b0;
    endcase
  end
  // inversion applies to the range only, never to arming or access type
  assign fire = access.valid && arm && type_ok && (in_range ^ invert);
endmodule
`default_nettype wire

// ### verification/core_bus_model.sv
// far-side model of the core address buses and the user mode line
`default_nettype none
module core_bus_model (
  // clock
  input wire logic sys_clk,
  // buses: 0 pmem, 1 dmem, 2 instr, 3 slave1, 4 slave2
  output var bp_ctrl_pkg::mem_access_t bus [5],
  output var logic core_user_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  bp_ctrl_pkg::mem_access_t stage [5];
  initial
  begin
    for (int i = 0; i < 5; i++)
    begin
      bus[i] = '0;
      stage[i] = '0;
    end
    core_user_mode = 1'b0;
  end
  // one access cycle on every staged bus, then idle
  // released lines show the inverse, so a stale address cannot pass for a live one
  task automatic pulse();
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++)
      bus[i] <= stage[i];
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++)
    begin
      bus[i] <= '{addr: ~stage[i].addr, valid: 1'b0, write: ~stage[i].write};
      stage[i].valid = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the breakpoint control unit
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ALL = 32'h8C38_00FF;
  localparam logic [1:0] OK = bp_ctrl_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = bp_ctrl_pkg::RESP_SLVERR;
  localparam logic [11:0] C = bp_ctrl_pkg::OFS_CTRL;
  localparam logic [11:0] R = bp_ctrl_pkg::OFS_RANGE;
  localparam int ARM [9] = '{19, 20, 20, 21, 21, 21, 21, 27, 26};
  localparam int INV [9] = '{10, 11, 12, 13, 14, 15, 16, 17, 17};
  localparam int BUS [9] = '{0, 1, 1, 2, 2, 2, 2, 3, 4};
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, hit, user_mode;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, flags;
  bp_ctrl_pkg::mem_access_t bus [5];
  int miscompares = 0;
  int check_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  core_bus_model cm (.sys_clk(sys_clk), .bus(bus), .core_user_mode(user_mode));
  bp_ctrl_unit DUT (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .instr_access(bus[2]),
    .program_memory_data_addr(bus[0]), .data_memory_data_addr(bus[1]), .slave_port1_access(bus[3]),
    .slave_port2_access(bus[4]), .core_user_mode(user_mode), .breakpoint_hit(hit),
    .breakpoint_hit_flags(flags));
  function automatic logic [31:0] lo(input int i);
    return 32'h0000_1000 * 32'(i + 1);
  endfunction
  function automatic logic [31:0] fl(input int i);
    return 32'h0000_0001 << bp_ctrl_pkg::STAT_POS[i];
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // address and data offered together; bready held until the response lands
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr <= {20'h0_0000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 40)
    begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        check("bresp", {30'h0, bresp}, {30'h0, r});
        break;
      end
    end
    bready <= 1'b0;
    if (n == 40)
    begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= {20'h0_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 40)
    begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        check("rdata", rdata, d);
        check("rresp", {30'h0, rresp}, {30'h0, r});
        break;
      end
    end
    rready <= 1'b0;
    if (n == 40)
    begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic put(input int e, input logic [31:0] a, input logic w);
    cm.stage[BUS[e]] = '{addr: a, valid: 1'b1, write: w};
  endtask
  // hit is registered, so it is looked at one cycle after the access
  task automatic probe(input logic eh, input logic [31:0] ef);
    cm.pulse();
    #1;
    check("breakpoint_hit", {31'h0, hit}, {31'h0, eh});
    check("hit_flags", flags, ef);
    wr(bp_ctrl_pkg::OFS_STAT, 32'hFFFF_FFFF, OK);
  endtask
  task automatic t_regs();
    rd(C, 32'h0000_0000, OK);
    rd(bp_ctrl_pkg::OFS_STAT, 32'h0000_0000, OK);
    wr(C, 32'hFFFF_FFFF, OK);
    rd(C, bp_ctrl_pkg::CTRL_RW_MASK, OK);
    wr(12'h0FC, ALL, ERR);
    rd(12'h0FC, 32'h0000_0000, ERR);
    for (int i = 0; i < 9; i++)
    begin
      wr(R + 12'(8 * i), lo(i), OK);
      wr(R + 12'(8 * i + 4), lo(i) + 32'h0000_07FF, OK);
    end
    rd(R + 12'h044, lo(8) + 32'h0000_07FF, OK);
  endtask
  // boundaries, inversion and arming for each of the nine breakpoints
  task automatic t_hits();
    wr(C, ALL, OK);
    for (int i = 0; i < 9; i++)
    begin
      put(i, lo(i) - 32'h0000_0001, 1'b0);
      probe(1'b0, '0);
      put(i, lo(i) + 32'h0000_07FF, 1'b1);
      probe(1'b1, fl(i));
      wr(C, ALL | (32'h0000_0001 << INV[i]), OK);
      put(i, lo(i) + 32'h0000_0800, 1'b0);
      probe(1'b1, fl(i));
      wr(C, ALL & ~(32'h0000_0001 << ARM[i]), OK);
      put(i, lo(i), 1'b0);
      probe(1'b0, '0);
      wr(C, ALL, OK);
    end
  endtask
  task automatic t_gate();
    wr(C, ALL & 32'h7FFF_FFFF, OK);
    put(0, lo(0), 1'b0);
    probe(1'b0, '0);
    wr(C, ALL | 32'h0200_0000, OK);
    put(0, lo(0), 1'b0);
    probe(1'b0, '0);
    cm.core_user_mode <= 1'b1;
    put(0, lo(0), 1'b0);
    probe(1'b1, fl(0));
    // instruction group armed too, so a missing instruction hit must veto the and
    wr(C, 32'h8138_00FF, OK);
    put(0, lo(0), 1'b0);
    probe(1'b0, fl(0));
    put(0, lo(0), 1'b0);
    put(1, lo(1), 1'b0);
    probe(1'b0, fl(0) | fl(1));
    put(0, lo(0), 1'b0);
    put(1, lo(1), 1'b0);
    put(3, lo(3), 1'b0);
    probe(1'b1, fl(0) | fl(1) | fl(3));
  endtask
  // every select value of every field, against reads and writes
  task automatic t_trig();
    int e [4] = '{0, 1, 2, 7};
    logic [31:0] c;
    logic x;
    for (int f = 0; f < 4; f++)
      for (int s = 0; s < 4; s++)
        for (int w = 0; w < 2; w++)
        begin
          c = (ALL & ~(32'h0000_0003 << (2 * f))) | (32'(s) << (2 * f));
          x = (s == 3) || (s == w + 1);
          wr(C, c, OK);
          put(e[f], lo(e[f]), w[0]);
          probe(x, x ? fl(e[f]) : '0);
        end
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_hits();
    t_gate();
    t_trig();
    test_done();
  end
endmodule
`default_nettype wire
